// *** common/msbfie_defines.vh ***
// Behaviour
// [RQ1] pre-decrement store: pointer minus one, then write
// [RQ2] post-increment store: write, then pointer plus one
// [RQ3] displaced store: pointer plus displacement, pointer kept
// [RQ4] direct store to absolute address, two cycles
// [RQ5] program byte load via Z, three cycles
// [RQ6] push stores register in two cycles
// [RQ7] pop loads register in two cycles
// [RQ8] io bit set or clear, other bits kept
// [RQ9] left shift, bit0 zero, flags Z C N V
// [RQ10] right shift, bit7 zero, flags Z C N V
// [RQ11] rotates through carry, carry takes shifted bit
// [RQ12] arithmetic right shift keeps bit seven
// [RQ13] nibble swap, one cycle, no flags
// [RQ14] set or clear any status flag by index
// [RQ15] copy register bit into transfer flag
// [RQ16] copy transfer flag into register bit
// [RQ17] watchdog restart and sleep, one cycle each
// [RQ18] break only signals debug, no flags
// [RQ19] signed flag set and clear, one cycle
// [RQ20] push then decrement; increment then pop
// [RQ21] port in and out move one byte
`ifndef MSBFIE_DEFINES_VH
`define MSBFIE_DEFINES_VH

`define MSBFIE_OP_NOP        5'h00
`define MSBFIE_OP_STORE_IND  5'h01
`define MSBFIE_OP_STORE_DISP 5'h02
`define MSBFIE_OP_STORE_DIR  5'h03
`define MSBFIE_OP_LOAD_PROG  5'h04
`define MSBFIE_OP_PUSH       5'h05
`define MSBFIE_OP_POP        5'h06
`define MSBFIE_OP_PORT_IN    5'h07
`define MSBFIE_OP_PORT_OUT   5'h08
`define MSBFIE_OP_IO_SET     5'h09
`define MSBFIE_OP_IO_CLR     5'h0A
`define MSBFIE_OP_SHL        5'h0B
`define MSBFIE_OP_SHR        5'h0C
`define MSBFIE_OP_ROL        5'h0D
`define MSBFIE_OP_ROR        5'h0E
`define MSBFIE_OP_ASR        5'h0F
`define MSBFIE_OP_SWAP       5'h10
`define MSBFIE_OP_FLAG_SET   5'h11
`define MSBFIE_OP_FLAG_CLR   5'h12
`define MSBFIE_OP_BIT_TO_T   5'h13
`define MSBFIE_OP_T_TO_BIT   5'h14
`define MSBFIE_OP_WDR        5'h15
`define MSBFIE_OP_SLEEP      5'h16
`define MSBFIE_OP_BREAK      5'h17

`define MSBFIE_MODE_PLAIN    2'h0
`define MSBFIE_MODE_POSTINC  2'h1
`define MSBFIE_MODE_PREDEC   2'h2
`define MSBFIE_MODE_TO_R0    2'h3

`define MSBFIE_PTR_X         2'h0
`define MSBFIE_PTR_Y         2'h1
`define MSBFIE_PTR_Z         2'h2

`define MSBFIE_IDX_X_LO      5'h1A
`define MSBFIE_IDX_Y_LO      5'h1C
`define MSBFIE_IDX_Z_LO      5'h1E
`define MSBFIE_IDX_Z_HI      5'h1F
`define MSBFIE_IDX_R0        5'h00

`define MSBFIE_FLAG_C        0
`define MSBFIE_FLAG_Z        1
`define MSBFIE_FLAG_N        2
`define MSBFIE_FLAG_V        3
`define MSBFIE_FLAG_S        4
`define MSBFIE_FLAG_H        5
`define MSBFIE_FLAG_T        6
`define MSBFIE_FLAG_I        7

`define MSBFIE_SP_RESET      16'h0000
`define MSBFIE_STATUS_REGISTER_RESET    8'h00

`endif

// *** rtl/msbfie_shift.v ***
`timescale 1ns/100ps
`default_nettype none
`include "msbfie_defines.vh"

module msbfie_shift (
  // operation
  input wire [4:0] op_i,
  input wire [7:0] data_i,
  input wire carry_i,
  // result
  output reg [7:0] res_o,
  output reg c_o,
  output reg z_o,
  output reg n_o,
  output reg v_o
);

  always @* begin
    res_o = data_i;
    c_o = carry_i;
    case (op_i)
      `MSBFIE_OP_SHL: begin
        res_o = {data_i[6:0], 1'b0}; // [RQ9]
        c_o = data_i[7];
      end
      `MSBFIE_OP_SHR: begin
        res_o = {1'b0, data_i[7:1]}; // [RQ10]
        c_o = data_i[0];
      end
      `MSBFIE_OP_ROL: begin
        res_o = {data_i[6:0], carry_i}; // [RQ11]
        c_o = data_i[7];
      end
      `MSBFIE_OP_ROR: begin
        res_o = {carry_i, data_i[7:1]}; // [RQ11]
        c_o = data_i[0];
      end
      `MSBFIE_OP_ASR: begin
        res_o = {data_i[7], data_i[7:1]}; // [RQ12]
        c_o = data_i[0];
      end
      default: begin
        res_o = data_i;
        c_o = carry_i;
      end
    endcase
    z_o = (res_o == 8'h00);
    n_o = res_o[7];
    // overflow is sign xor carry after every shift
    v_o = n_o ^ c_o;
  end

endmodule // msbfie_shift
`default_nettype wire

// *** rtl/msbfie_core.v ***
`timescale 1ns/100ps
`default_nettype none
`include "msbfie_defines.vh"

module msbfie_core #(
  parameter [15:0] SP_RESET = `MSBFIE_SP_RESET
) (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire srst_i,
  input wire ce_i,
  // decoded instruction
  input wire op_valid_i,
  input wire [4:0] op_code_i,
  input wire [1:0] op_mode_i,
  input wire [1:0] op_ptr_i,
  input wire [4:0] op_rd_i,
  input wire [4:0] op_rr_i,
  input wire [2:0] op_bit_i,
  input wire [5:0] op_disp_i,
  input wire [15:0] op_addr_i,
  input wire [5:0] op_io_i,
  output reg op_ready_o,
  output reg op_done_o,
  // data memory
  output reg [15:0] dm_addr_o,
  output reg [7:0] dm_wdata_o,
  output reg dm_we_o,
  output reg dm_re_o,
  input wire [7:0] dm_rdata_i,
  // program memory, word addressed
  output reg [14:0] pm_addr_o,
  output reg pm_re_o,
  input wire [15:0] pm_rdata_i,
  // io space
  output reg [5:0] io_addr_o,
  output reg [7:0] io_wdata_o,
  output reg io_we_o,
  output reg io_re_o,
  input wire [7:0] io_rdata_i,
  // register file preload and observation
  input wire rf_load_i,
  input wire [4:0] rf_load_idx_i,
  input wire [7:0] rf_load_data_i,
  input wire [4:0] rf_peek_idx_i,
  output reg [7:0] rf_peek_o,
  // core state and control strobes
  output reg [7:0] status_register_o,
  output reg [15:0] sp_o,
  output reg watchdog_restart_o,
  output reg sleep_req_o,
  output reg break_o
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_MEM = 4'b0010;
  localparam [3:0] ST_PM1 = 4'b0100;
  localparam [3:0] ST_PM2 = 4'b1000;

  reg [7:0] rf [0:31];
  reg [3:0] state;
  reg [4:0] cur_op;
  reg [4:0] cur_rd;
  reg [1:0] cur_mode;
  reg [7:0] cur_mask;
  reg cur_byte_hi;
  integer i;

  wire accept;
  wire [4:0] ptr_lo_idx;
  wire [4:0] ptr_hi_idx;
  wire [15:0] ptr_val;
  wire [15:0] ptr_inc;
  wire [15:0] ptr_dec;
  wire [15:0] disp_addr;
  wire [15:0] z_val;
  wire [15:0] z_inc;
  wire [15:0] sp_inc;
  wire [7:0] rd_val;
  wire [7:0] rr_val;
  wire [7:0] bit_mask;
  wire [7:0] sh_res;
  wire sh_c;
  wire sh_z;
  wire sh_n;
  wire sh_v;

  // ready is a flop: ops are only taken while idle
  assign accept = op_valid_i & op_ready_o & (state == ST_IDLE);

  assign ptr_lo_idx = (op_ptr_i == `MSBFIE_PTR_X) ? `MSBFIE_IDX_X_LO :
                      (op_ptr_i == `MSBFIE_PTR_Y) ? `MSBFIE_IDX_Y_LO : `MSBFIE_IDX_Z_LO;
  assign ptr_hi_idx = ptr_lo_idx + 5'h01;
  assign ptr_val = {rf[ptr_hi_idx], rf[ptr_lo_idx]};
  assign ptr_inc = ptr_val + 16'h0001;
  assign ptr_dec = ptr_val - 16'h0001;
  assign disp_addr = ptr_val + {10'h000, op_disp_i};
  assign z_val = {rf[`MSBFIE_IDX_Z_HI], rf[`MSBFIE_IDX_Z_LO]};
  assign z_inc = z_val + 16'h0001;
  assign sp_inc = sp_o + 16'h0001;
  assign rd_val = rf[op_rd_i];
  assign rr_val = rf[op_rr_i];
  assign bit_mask = 8'h01 << op_bit_i;

  msbfie_shift u_shift (
    .op_i(op_code_i),
    .data_i(rd_val),
    .carry_i(status_register_o[`MSBFIE_FLAG_C]),
    .res_o(sh_res),
    .c_o(sh_c),
    .z_o(sh_z),
    .n_o(sh_n),
    .v_o(sh_v)
  );

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      cur_op <= `MSBFIE_OP_NOP;
      cur_rd <= 5'h00;
      cur_mode <= `MSBFIE_MODE_PLAIN;
      cur_mask <= 8'h00;
      cur_byte_hi <= 1'b0;
      op_ready_o <= 1'b1;
      op_done_o <= 1'b0;
      dm_addr_o <= 16'h0000;
      dm_wdata_o <= 8'h00;
      dm_we_o <= 1'b0;
      dm_re_o <= 1'b0;
      pm_addr_o <= 15'h0000;
      pm_re_o <= 1'b0;
      io_addr_o <= 6'h00;
      io_wdata_o <= 8'h00;
      io_we_o <= 1'b0;
      io_re_o <= 1'b0;
      rf_peek_o <= 8'h00;
      status_register_o <= `MSBFIE_STATUS_REGISTER_RESET;
      sp_o <= SP_RESET;
      watchdog_restart_o <= 1'b0;
      sleep_req_o <= 1'b0;
      break_o <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        rf[i] <= 8'h00;
      end
    end else if (ce_i) begin
      // strobes pulse for one cycle
      op_done_o <= 1'b0;
      dm_we_o <= 1'b0;
      dm_re_o <= 1'b0;
      pm_re_o <= 1'b0;
      io_we_o <= 1'b0;
      io_re_o <= 1'b0;
      watchdog_restart_o <= 1'b0;
      sleep_req_o <= 1'b0;
      break_o <= 1'b0;
      rf_peek_o <= rf[rf_peek_idx_i];
      case (state)
        ST_IDLE: begin
          if (accept) begin
            cur_op <= op_code_i;
            cur_rd <= op_rd_i;
            cur_mode <= op_mode_i;
            cur_mask <= bit_mask;
            case (op_code_i)
              `MSBFIE_OP_STORE_IND: begin
                dm_we_o <= 1'b1;
                dm_wdata_o <= rr_val;
                op_ready_o <= 1'b0;
                state <= ST_MEM;
                if (op_mode_i == `MSBFIE_MODE_PREDEC) begin
                  // address is the already reduced pointer
                  dm_addr_o <= ptr_dec; // [RQ1]
                  rf[ptr_lo_idx] <= ptr_dec[7:0]; // [RQ1]
                  rf[ptr_hi_idx] <= ptr_dec[15:8];
                end else if (op_mode_i == `MSBFIE_MODE_POSTINC) begin
                  dm_addr_o <= ptr_val; // [RQ2]
                  rf[ptr_lo_idx] <= ptr_inc[7:0]; // [RQ2]
                  rf[ptr_hi_idx] <= ptr_inc[15:8];
                end else begin
                  dm_addr_o <= ptr_val;
                end
              end
              `MSBFIE_OP_STORE_DISP: begin
                // pointer pair is never written back
                dm_addr_o <= disp_addr; // [RQ3]
                dm_wdata_o <= rr_val;
                dm_we_o <= 1'b1;
                op_ready_o <= 1'b0;
                state <= ST_MEM;
              end
              `MSBFIE_OP_STORE_DIR: begin
                dm_addr_o <= op_addr_i; // [RQ4]
                dm_wdata_o <= rr_val;
                dm_we_o <= 1'b1;
                op_ready_o <= 1'b0;
                state <= ST_MEM;
              end
              `MSBFIE_OP_LOAD_PROG: begin
                // word fetch, byte chosen by the low pointer bit
                pm_addr_o <= z_val[15:1]; // [RQ5]
                pm_re_o <= 1'b1;
                cur_byte_hi <= z_val[0];
                op_ready_o <= 1'b0;
                state <= ST_PM1;
              end
              `MSBFIE_OP_PUSH: begin
                dm_addr_o <= sp_o; // [RQ20]
                dm_wdata_o <= rr_val; // [RQ6]
                dm_we_o <= 1'b1;
                sp_o <= sp_o - 16'h0001; // [RQ20]
                op_ready_o <= 1'b0;
                state <= ST_MEM;
              end
              `MSBFIE_OP_POP: begin
                dm_addr_o <= sp_inc; // [RQ20]
                dm_re_o <= 1'b1; // [RQ7]
                sp_o <= sp_inc;
                op_ready_o <= 1'b0;
                state <= ST_MEM;
              end
              `MSBFIE_OP_PORT_IN: begin
                // io read data is only seen at the next edge
                io_addr_o <= op_io_i; // [RQ21]
                io_re_o <= 1'b1;
                op_ready_o <= 1'b0;
                state <= ST_MEM;
              end
              `MSBFIE_OP_PORT_OUT: begin
                io_addr_o <= op_io_i; // [RQ21]
                io_wdata_o <= rr_val;
                io_we_o <= 1'b1;
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_IO_SET, `MSBFIE_OP_IO_CLR: begin
                // read phase of a read-modify-write on the io byte
                io_addr_o <= op_io_i; // [RQ8]
                io_re_o <= 1'b1;
                op_ready_o <= 1'b0;
                state <= ST_MEM;
              end
              `MSBFIE_OP_SHL, `MSBFIE_OP_SHR, `MSBFIE_OP_ROL,
              `MSBFIE_OP_ROR, `MSBFIE_OP_ASR: begin
                rf[op_rd_i] <= sh_res; // [RQ9] [RQ10] [RQ11] [RQ12]
                status_register_o[`MSBFIE_FLAG_C] <= sh_c; // [RQ11]
                status_register_o[`MSBFIE_FLAG_Z] <= sh_z; // [RQ9] [RQ10]
                status_register_o[`MSBFIE_FLAG_N] <= sh_n;
                status_register_o[`MSBFIE_FLAG_V] <= sh_v;
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_SWAP: begin
                rf[op_rd_i] <= {rd_val[3:0], rd_val[7:4]}; // [RQ13]
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_FLAG_SET: begin
                // serves every dedicated flag form
                status_register_o[op_bit_i] <= 1'b1; // [RQ14] [RQ19]
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_FLAG_CLR: begin
                status_register_o[op_bit_i] <= 1'b0; // [RQ14] [RQ19]
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_BIT_TO_T: begin
                status_register_o[`MSBFIE_FLAG_T] <= rr_val[op_bit_i]; // [RQ15]
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_T_TO_BIT: begin
                if (status_register_o[`MSBFIE_FLAG_T]) begin
                  rf[op_rd_i] <= rd_val | bit_mask; // [RQ16]
                end else begin
                  rf[op_rd_i] <= rd_val & ~bit_mask; // [RQ16]
                end
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_WDR: begin
                watchdog_restart_o <= 1'b1; // [RQ17]
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_SLEEP: begin
                sleep_req_o <= 1'b1; // [RQ17]
                op_done_o <= 1'b1;
              end
              `MSBFIE_OP_BREAK: begin
                // debug hand-off only; the core itself keeps running
                break_o <= 1'b1; // [RQ18]
                op_done_o <= 1'b1;
              end
              default: begin
                op_done_o <= 1'b1;
              end
            endcase
          end else if (rf_load_i) begin
            // preload only between operations so it cannot race a result
            rf[rf_load_idx_i] <= rf_load_data_i;
          end
        end
        ST_MEM: begin
          case (cur_op)
            `MSBFIE_OP_POP: begin
              rf[cur_rd] <= dm_rdata_i; // [RQ7]
            end
            `MSBFIE_OP_PORT_IN: begin
              rf[cur_rd] <= io_rdata_i; // [RQ21]
            end
            `MSBFIE_OP_IO_SET: begin
              io_wdata_o <= io_rdata_i | cur_mask; // [RQ8]
              io_we_o <= 1'b1;
            end
            `MSBFIE_OP_IO_CLR: begin
              io_wdata_o <= io_rdata_i & ~cur_mask; // [RQ8]
              io_we_o <= 1'b1;
            end
            default: begin
              cur_mask <= cur_mask;
            end
          endcase
          op_done_o <= 1'b1; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ6]
          op_ready_o <= 1'b1;
          state <= ST_IDLE;
        end
        ST_PM1: begin
          state <= ST_PM2;
        end
        ST_PM2: begin
          if (cur_mode == `MSBFIE_MODE_TO_R0) begin
            rf[`MSBFIE_IDX_R0] <= cur_byte_hi ? pm_rdata_i[15:8] : pm_rdata_i[7:0]; // [RQ5]
          end else begin
            rf[cur_rd] <= cur_byte_hi ? pm_rdata_i[15:8] : pm_rdata_i[7:0]; // [RQ5]
          end
          if (cur_mode == `MSBFIE_MODE_POSTINC) begin
            rf[`MSBFIE_IDX_Z_LO] <= z_inc[7:0]; // [RQ5]
            rf[`MSBFIE_IDX_Z_HI] <= z_inc[15:8];
          end
          op_done_o <= 1'b1;
          op_ready_o <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          op_ready_o <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // msbfie_core
`default_nettype wire

// *** tb/msbfie_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module msbfie_mem_model (
  // clock
  input wire logic ref_clk_i,
  // data memory
  input wire logic [15:0] dm_addr_i,
  input wire logic [7:0] dm_wdata_i,
  input wire logic dm_we_i,
  input wire logic dm_re_i,
  output logic [7:0] dm_rdata_o,
  // program memory
  input wire logic [14:0] pm_addr_i,
  input wire logic pm_re_i,
  output logic [15:0] pm_rdata_o,
  // io space
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_we_i,
  input wire logic io_re_i,
  output logic [7:0] io_rdata_o
);
  logic [7:0] dm [0:65535];
  logic [15:0] pm [0:255];
  logic [7:0] io [0:63];
  // outside a read the lines show the inverse, so a stray sample fails
  assign dm_rdata_o = dm_re_i ? dm[dm_addr_i] : ~dm[dm_addr_i];
  assign io_rdata_o = io_re_i ? io[io_addr_i] : ~io[io_addr_i];
  always @(posedge ref_clk_i) begin
    if (dm_we_i)
      dm[dm_addr_i] <= dm_wdata_i;
    if (io_we_i)
      io[io_addr_i] <= io_wdata_i;
    if (pm_re_i)
      pm_rdata_o <= pm[pm_addr_i[7:0]];
  end
endmodule // msbfie_mem_model
`default_nettype wire

// *** tb/msbfie_core_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "msbfie_defines.vh"
module msbfie_core_monitor (
  // clock, reset, instruction port
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire logic [4:0] op_code_i,
  input wire logic [2:0] op_bit_i,
  input wire logic op_ready_o,
  input wire logic op_done_o,
  // memories, io, state
  input wire logic [15:0] dm_addr_o,
  input wire logic dm_we_o,
  input wire logic dm_re_o,
  input wire logic pm_re_o,
  input wire logic [7:0] io_wdata_o,
  input wire logic io_we_o,
  input wire logic io_re_o,
  input wire logic [7:0] io_rdata_i,
  input wire logic [7:0] status_register_o,
  input wire logic [15:0] sp_o,
  input wire logic watchdog_restart_o
);
  logic acc;
  logic st;
  assign acc = ce_i & op_valid_i & op_ready_o;
  assign st = acc & (op_code_i == `MSBFIE_OP_STORE_IND || op_code_i == `MSBFIE_OP_STORE_DISP
    || op_code_i == `MSBFIE_OP_STORE_DIR);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  store_two_cycle_a: assert property (st |=> dm_we_o && !op_ready_o ##1 op_done_o && !dm_we_o)
    else $error("store timing");
  store_flags_kept_a: assert property (st |-> ##2 status_register_o == $past(status_register_o, 2))
    else $error("store changed flags");
  prog_three_cycle_a: assert property (acc && op_code_i == `MSBFIE_OP_LOAD_PROG
    |=> pm_re_o && !op_done_o ##1 !op_done_o ##1 op_done_o)
    else $error("program load timing");
  push_order_a: assert property (acc && op_code_i == `MSBFIE_OP_PUSH
    |=> dm_we_o && dm_addr_o == $past(sp_o) && sp_o == $past(sp_o) - 16'h0001)
    else $error("push order");
  pop_order_a: assert property (acc && op_code_i == `MSBFIE_OP_POP
    |=> dm_re_o && sp_o == $past(sp_o) + 16'h0001 && dm_addr_o == sp_o ##1 op_done_o)
    else $error("pop order");
  io_bit_merge_a: assert property (acc && op_code_i == `MSBFIE_OP_IO_SET |=> io_re_o
    ##1 io_we_o && io_wdata_o == ($past(io_rdata_i) | (8'h01 << $past(op_bit_i, 2))))
    else $error("io bit merge");
  flag_set_one_a: assert property (acc && op_code_i == `MSBFIE_OP_FLAG_SET
    |=> status_register_o == ($past(status_register_o) | (8'h01 << $past(op_bit_i))))
    else $error("flag set wrong");
  wdr_strobe_a: assert property (acc && op_code_i == `MSBFIE_OP_WDR
    |=> watchdog_restart_o && op_done_o && $stable(status_register_o))
    else $error("watchdog strobe");
  cover property (acc && op_code_i == `MSBFIE_OP_POP);
  cover property (acc && op_code_i == `MSBFIE_OP_LOAD_PROG);
  cover property (acc && op_code_i == `MSBFIE_OP_IO_SET);
endmodule // msbfie_core_monitor
bind msbfie_core msbfie_core_monitor i_msbfie_core_monitor (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .ce_i(ce_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .op_bit_i(op_bit_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o), .dm_addr_o(dm_addr_o),
  .dm_we_o(dm_we_o), .dm_re_o(dm_re_o), .pm_re_o(pm_re_o), .io_wdata_o(io_wdata_o),
  .io_we_o(io_we_o), .io_re_o(io_re_o), .io_rdata_i(io_rdata_i),
  .status_register_o(status_register_o), .sp_o(sp_o), .watchdog_restart_o(watchdog_restart_o));
`default_nettype wire

// *** tb/mcu_store_bit_flag_instr_exec_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "msbfie_defines.vh"
module mcu_store_bit_flag_instr_exec_bench;
  logic ref_clk_i, srst_i, ce_i, op_valid_i, rf_load_i, ready, done, dm_we, dm_re, pm_re;
  logic io_we, io_re, watchdog_restart, slp, brk, cx;
  logic [4:0] op_code_i, op_rd_i, op_rr_i, rf_load_idx_i, rf_peek_idx_i;
  logic [1:0] op_mode_i, op_ptr_i;
  logic [2:0] op_bit_i;
  logic [5:0] op_disp_i, op_io_i, io_addr;
  logic [15:0] op_addr_i, dm_addr, pm_rdata, sp, w;
  logic [7:0] rf_load_data_i, dm_wdata, dm_rdata, io_wdata, io_rdata, peek_v, sr_o, sr, v, rx;
  logic [14:0] pm_addr;
  integer miscompares, checks, cycles, i, j;
  msbfie_core #(.SP_RESET(16'h0400)) i_msbfie_core (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .ce_i(ce_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_mode_i(op_mode_i),
    .op_ptr_i(op_ptr_i), .op_rd_i(op_rd_i), .op_rr_i(op_rr_i), .op_bit_i(op_bit_i),
    .op_disp_i(op_disp_i), .op_addr_i(op_addr_i), .op_io_i(op_io_i), .op_ready_o(ready),
    .op_done_o(done), .dm_addr_o(dm_addr), .dm_wdata_o(dm_wdata), .dm_we_o(dm_we),
    .dm_re_o(dm_re), .dm_rdata_i(dm_rdata), .pm_addr_o(pm_addr), .pm_re_o(pm_re),
    .pm_rdata_i(pm_rdata), .io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_we_o(io_we),
    .io_re_o(io_re), .io_rdata_i(io_rdata), .rf_load_i(rf_load_i), .rf_load_idx_i(rf_load_idx_i),
    .rf_load_data_i(rf_load_data_i), .rf_peek_idx_i(rf_peek_idx_i), .rf_peek_o(peek_v),
    .status_register_o(sr_o), .sp_o(sp), .watchdog_restart_o(watchdog_restart), .sleep_req_o(slp),
    .break_o(brk));
  msbfie_mem_model i_msbfie_mem_model (.ref_clk_i(ref_clk_i), .dm_addr_i(dm_addr),
    .dm_wdata_i(dm_wdata), .dm_we_i(dm_we), .dm_re_i(dm_re), .dm_rdata_o(dm_rdata),
    .pm_addr_i(pm_addr), .pm_re_i(pm_re), .pm_rdata_o(pm_rdata), .io_addr_i(io_addr),
    .io_wdata_i(io_wdata), .io_we_i(io_we), .io_re_i(io_re), .io_rdata_o(io_rdata));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task final_report;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task load(input [4:0] idx, input [7:0] d);
    begin
      rf_load_i = 1'b1;
      rf_load_idx_i = idx;
      rf_load_data_i = d;
      @(negedge ref_clk_i);
    end
  endtask
  task peek(input [4:0] idx);
    begin
      rf_peek_idx_i = idx;
      @(negedge ref_clk_i);
      v = peek_v;
    end
  endtask
  task ptr(input [4:0] lo, input [15:0] val);
    begin
      load(lo, val[7:0]);
      load(lo + 5'h01, val[15:8]);
    end
  endtask
  task rdptr(input [4:0] lo);
    begin
      peek(lo);
      w[7:0] = v;
      peek(lo + 5'h01);
      w[15:8] = v;
    end
  endtask
  task op(input [4:0] c, rd, rr, input [2:0] b, input [15:0] cyc);
    run(c, 2'h0, 2'h0, rd, rr, b, 16'h0000, cyc);
  endtask
  task run(input [4:0] c, input [1:0] m, p, input [4:0] rd, rr, input [2:0] b,
           input [15:0] a, input [15:0] cyc);
    integer n;
    begin
      @(negedge ref_clk_i);
      rf_load_i = 1'b0;
      op_code_i = c;
      op_mode_i = m;
      op_ptr_i = p;
      op_rd_i = rd;
      op_rr_i = rr;
      op_bit_i = b;
      op_addr_i = a;
      op_disp_i = a[5:0];
      op_io_i = a[5:0];
      op_valid_i = 1'b1;
      @(negedge ref_clk_i);
      op_valid_i = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 8) begin
        @(negedge ref_clk_i);
        n = n + 1;
      end
      check(n[15:0], cyc);
    end
  endtask
  task t_store;
    begin
      load(5'h05, 8'h3C);
      ptr(`MSBFIE_IDX_X_LO, 16'h0110);
      run(`MSBFIE_OP_STORE_IND, `MSBFIE_MODE_PREDEC, `MSBFIE_PTR_X, 5'h00, 5'h05, 3'h0, 16'h0000, 2);
      check(i_msbfie_mem_model.dm[16'h010F], 16'h003C);
      rdptr(`MSBFIE_IDX_X_LO);
      check(w, 16'h010F);
      ptr(`MSBFIE_IDX_Y_LO, 16'h0200);
      run(`MSBFIE_OP_STORE_IND, `MSBFIE_MODE_POSTINC, `MSBFIE_PTR_Y, 5'h00, 5'h05, 3'h0, 16'h0000, 2);
      check(i_msbfie_mem_model.dm[16'h0200], 16'h003C);
      rdptr(`MSBFIE_IDX_Y_LO);
      check(w, 16'h0201);
      ptr(`MSBFIE_IDX_Z_LO, 16'h0300);
      run(`MSBFIE_OP_STORE_DISP, `MSBFIE_MODE_PLAIN, `MSBFIE_PTR_Z, 5'h00, 5'h05, 3'h0, 16'h0005, 2);
      check(i_msbfie_mem_model.dm[16'h0305], 16'h003C);
      rdptr(`MSBFIE_IDX_Z_LO);
      check(w, 16'h0300);
      run(`MSBFIE_OP_STORE_DIR, 2'h0, 2'h0, 5'h00, 5'h05, 3'h0, 16'h1234, 2);
      check(i_msbfie_mem_model.dm[16'h1234], 16'h003C);
      check(sr_o, sr);
      op(`MSBFIE_OP_PUSH, 5'h00, 5'h05, 3'h0, 2);
      check(i_msbfie_mem_model.dm[16'h0400], 16'h003C);
      check(sp, 16'h03FF);
      op(`MSBFIE_OP_POP, 5'h07, 5'h00, 3'h0, 2);
      peek(5'h07);
      check(v, 16'h003C);
      check(sp, 16'h0400);
      $display("store test done");
    end
  endtask
  task t_prog_io;
    begin
      ptr(`MSBFIE_IDX_Z_LO, 16'h0100);
      run(`MSBFIE_OP_LOAD_PROG, `MSBFIE_MODE_PLAIN, `MSBFIE_PTR_Z, 5'h09, 5'h00, 3'h0, 16'h0000, 3);
      peek(5'h09);
      check(v, 16'h00EF);
      ptr(`MSBFIE_IDX_Z_LO, 16'h0101);
      run(`MSBFIE_OP_LOAD_PROG, `MSBFIE_MODE_TO_R0, `MSBFIE_PTR_Z, 5'h00, 5'h00, 3'h0, 16'h0000, 3);
      peek(`MSBFIE_IDX_R0);
      check(v, 16'h00BE);
      run(`MSBFIE_OP_LOAD_PROG, `MSBFIE_MODE_POSTINC, `MSBFIE_PTR_Z, 5'h08, 5'h00, 3'h0, 16'h0000, 3);
      peek(5'h08);
      check(v, 16'h00BE);
      rdptr(`MSBFIE_IDX_Z_LO);
      check(w, 16'h0102);
      run(`MSBFIE_OP_IO_SET, 2'h0, 2'h0, 5'h00, 5'h00, 3'h7, 16'h0012, 2);
      check(io_wdata, 16'h008F);
      run(`MSBFIE_OP_IO_CLR, 2'h0, 2'h0, 5'h00, 5'h00, 3'h0, 16'h0012, 2);
      check(io_wdata, 16'h008E);
      run(`MSBFIE_OP_PORT_OUT, 2'h0, 2'h0, 5'h00, 5'h05, 3'h0, 16'h0020, 1);
      check(io_wdata, 16'h003C);
      run(`MSBFIE_OP_PORT_IN, 2'h0, 2'h0, 5'h0A, 5'h00, 3'h0, 16'h0012, 2);
      peek(5'h0A);
      check(v, 16'h008E);
      check(sr_o, sr);
      $display("io test done");
    end
  endtask
  task t_misc;
    begin
      load(5'h10, 8'hA5);
      op(`MSBFIE_OP_SWAP, 5'h10, 5'h00, 3'h0, 1);
      peek(5'h10);
      check(v, 16'h005A);
      for (i = 0; i < 8; i = i + 1) begin
        op(`MSBFIE_OP_FLAG_SET, 5'h00, 5'h00, i[2:0], 1);
        sr[i] = 1'b1;
        check(sr_o, sr);
        op(`MSBFIE_OP_FLAG_CLR, 5'h00, 5'h00, i[2:0], 1);
        sr[i] = 1'b0;
        check(sr_o, sr);
      end
      load(5'h10, 8'h02);
      op(`MSBFIE_OP_BIT_TO_T, 5'h00, 5'h10, 3'h1, 1);
      sr[`MSBFIE_FLAG_T] = 1'b1;
      check(sr_o, sr);
      load(5'h11, 8'h00);
      op(`MSBFIE_OP_T_TO_BIT, 5'h11, 5'h00, 3'h3, 1);
      peek(5'h11);
      check(v, 16'h0008);
      op(`MSBFIE_OP_WDR, 5'h00, 5'h00, 3'h0, 1);
      check(watchdog_restart, 1'b1);
      op(`MSBFIE_OP_SLEEP, 5'h00, 5'h00, 3'h0, 1);
      check(slp, 1'b1);
      op(`MSBFIE_OP_BREAK, 5'h00, 5'h00, 3'h0, 1);
      check(brk, 1'b1);
      check(sr_o, sr);
      $display("flag test done");
    end
  endtask
  task t_shift;
    begin
      op(`MSBFIE_OP_FLAG_SET, 5'h00, 5'h00, 3'h4, 1);
      sr[`MSBFIE_FLAG_S] = 1'b1;
      for (i = 0; i < 5; i = i + 1) begin
        for (j = 0; j < 2; j = j + 1) begin
          cx = (j == 0);
          w[7:0] = (j == 0) ? 8'h81 : 8'h01;
          op(cx ? `MSBFIE_OP_FLAG_SET : `MSBFIE_OP_FLAG_CLR, 5'h00, 5'h00, 3'h0, 1);
          sr[`MSBFIE_FLAG_C] = cx;
          load(5'h10, w[7:0]);
          op(`MSBFIE_OP_SHL + i[4:0], 5'h10, 5'h00, 3'h0, 1);
          case (i)
            0: {cx, rx} = {w[7:0], 1'b0};
            1: {rx, cx} = {1'b0, w[7:0]};
            2: {cx, rx} = {w[7:0], cx};
            3: {rx, cx} = {cx, w[7:0]};
            default: {rx, cx} = {w[7], w[7:0]};
          endcase
          sr[3:0] = {rx[7] ^ cx, rx[7], rx == 8'h00, cx};
          peek(5'h10);
          check(v, rx);
          check(sr_o, sr);
        end
      end
      $display("shift test done");
    end
  endtask
  initial begin
    {srst_i, ce_i, op_valid_i, rf_load_i} = 4'hC;
    {op_code_i, op_mode_i, op_ptr_i, op_rd_i, op_rr_i, op_bit_i} = 22'h0;
    {op_disp_i, op_io_i, op_addr_i} = 28'h0;
    {rf_load_idx_i, rf_load_data_i, rf_peek_idx_i} = 18'h0;
    {miscompares, checks, cycles} = 96'h0;
    sr = 8'h00;
    i_msbfie_mem_model.pm[8'h80] = 16'hBEEF;
    i_msbfie_mem_model.io[6'h12] = 8'h0F;
    repeat (2) @(negedge ref_clk_i);
    srst_i = 1'b0;
    t_store;
    t_prog_io;
    t_misc;
    t_shift;
    final_report;
  end
endmodule // mcu_store_bit_flag_instr_exec_bench
`default_nettype wire
